// ---- common/rdbe_pkg.sv ----
// Constants and types shared by the descriptor block engine and its buffer.
// Assumes a 16-bit word-addressed memory and a 16-bit descriptor word.
package rdbe_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BASE_W = 12;
    localparam int SA_W = 5;
    localparam int WC_W = 6;
    localparam int EV_W = 3;
    // Table region offsets for rx/tx subaddress and rx/tx mode code.
    localparam logic [ADDR_W-1:0] OFS_RX_SA = 16'h0000;
    localparam logic [ADDR_W-1:0] OFS_TX_SA = 16'h0080;
    localparam logic [ADDR_W-1:0] OFS_RX_MC = 16'h0100;
    localparam logic [ADDR_W-1:0] OFS_TX_MC = 16'h0180;
    localparam logic [ADDR_W-1:0] DATA_OFS = 16'h0002;
    // Descriptor word indices.
    localparam logic [1:0] IDX_CW = 2'h0;
    localparam logic [1:0] IDX_PA = 2'h1;
    localparam logic [1:0] IDX_PB = 2'h2;
    localparam logic [1:0] IDX_PBC = 2'h3;
    // Control word fields.
    localparam int CW_SEP_BC = 0;
    localparam int CW_BC_SEEN = 1;
    localparam int CW_BUF_SEL = 2;
    localparam int CW_TOUCHED = 4;
    localparam int CW_BRD_IRQ = 5;
    localparam int CW_ACC_IRQ = 6;
    localparam int CW_CZ_IRQ = 7;
    localparam int CW_CNT_LSB = 8;
    localparam int CW_CNT_MSB = 15;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    // Mode codes with automatic broadcast illegalization.
    localparam logic [SA_W-1:0] MC_AUTO_A = 5'h00;
    localparam logic [SA_W-1:0] MC_AUTO_B = 5'h02;
    // Event bit positions in the pending and log words.
    localparam int EV_BRD = 0;
    localparam int EV_ACC = 1;
    localparam int EV_CZ = 2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RDESC = 3'h1,
        ST_DATA = 3'h3,
        ST_POST = 3'h2,
        ST_LOG = 3'h6
    } rdbe_state_t;
endpackage : rdbe_pkg

// ---- common/rdbe_stream_if.sv ----
// Valid/ready word stream between the engine and its two-entry buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rdbe_stream_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface : rdbe_stream_if

// ---- rtl/rdbe_buf2.sv ----
// Two-entry buffer that absorbs receive words while memory is busy.
// Assumes one clock; full and empty are exact, so a stall back-pressures.
`timescale 1ns/1ps
module rdbe_buf2 (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    rdbe_stream_if.snk in_s,
    rdbe_stream_if.src out_s
);
    logic [rdbe_pkg::DATA_W-1:0] mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // Ready and valid come straight from the fill count.
    assign in_s.ready = (cnt_q != 2'h2);
    assign out_s.valid = (cnt_q != 2'h0);
    assign out_s.data = mem_q[rp_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // Storage is written only on a push, so no reset is needed on it.
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wp_q] <= in_s.data;
        end
    end

    // Pointers and count move together; a push and pop in one cycle cancel.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // The fill count must never pass two, whatever the two sides do.
    a_no_overflow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cnt_q != 2'h3) else $error("buffer fill count overflowed");
endmodule : rdbe_buf2

// ---- rtl/rdbe_engine.sv ----
// Descriptor block engine of a serial-bus remote terminal: fetches the
// descriptor for each command, moves data words, then posts the update.
// Assumes the protocol engine and the memory sit on the same clock.
`timescale 1ns/1ps
module rdbe_engine (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [rdbe_pkg::BASE_W-1:0] table_base_i,
    input wire logic pingpong_en_i,
    input wire logic rev_1553a_i,
    input wire logic status_word_transmit_option_i,
    input wire logic terminal_active_i,
    input wire logic cmd_tx_i,
    input wire logic cmd_mode_i,
    input wire logic [rdbe_pkg::SA_W-1:0] cmd_sa_i,
    input wire logic cmd_bcast_i,
    input wire logic cmd_illegal_i,
    input wire logic [rdbe_pkg::WC_W-1:0] cmd_word_count_i,
    input wire logic msg_error_i,
    input wire logic msg_done_i,
    input wire logic rx_valid_i,
    input wire logic [rdbe_pkg::DATA_W-1:0] rx_data_i,
    output logic rx_ready_o,
    output logic tx_valid_o,
    output logic [rdbe_pkg::DATA_W-1:0] tx_data_o,
    input wire logic tx_ready_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic mem_burst_o,
    output logic [rdbe_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [rdbe_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic [rdbe_pkg::DATA_W-1:0] mem_rdata_i,
    input wire logic mem_ack_i,
    input wire logic [rdbe_pkg::EV_W-1:0] irq_mask_i,
    input wire logic [rdbe_pkg::ADDR_W-1:0] irq_log_addr_i,
    input wire logic [rdbe_pkg::EV_W-1:0] irq_clear_i,
    output logic [rdbe_pkg::EV_W-1:0] irq_pending_o,
    output logic message_irq_out_o,
    output logic busy_o
);
    rdbe_pkg::rdbe_state_t state_q;
    logic [1:0] idx_q;
    logic [rdbe_pkg::DATA_W-1:0] desc_q [4];
    logic ta_q;
    logic tr_q, mode_q, bc_q, ill_q, pp_q, err_q, done_q, txv_q, mreq_q, mwe_q;
    logic [rdbe_pkg::SA_W-1:0] sa_q;
    logic [rdbe_pkg::WC_W-1:0] wc_q;
    logic [rdbe_pkg::WC_W-1:0] cnt_q;
    logic [rdbe_pkg::BASE_W-1:0] base_q;
    logic [rdbe_pkg::ADDR_W-1:0] maddr_q;
    logic [rdbe_pkg::DATA_W-1:0] mdata_q;
    logic [rdbe_pkg::DATA_W-1:0] txd_q;
    logic [rdbe_pkg::EV_W-1:0] pend_q;
    logic [2:0] rd_cnt_q;
    logic start, auto_ill, data_end, dec, bc_valid, post_wr, post_step;
    logic ld_rd_desc, ld_wr_rx, ld_rd_tx, ld_wr_post, ld_wr_log, launch, log_need;
    logic [1:0] sel_idx;
    logic [3:0] upd;
    logic [7:0] cnt_f;
    logic [rdbe_pkg::DATA_W-1:0] cw, new_cw, ptr_end, post_data, log_word, ld_data;
    logic [rdbe_pkg::ADDR_W-1:0] desc_addr, region, ptr_base, ld_addr;
    logic [rdbe_pkg::EV_W-1:0] ev;

    rdbe_stream_if #(.W(rdbe_pkg::DATA_W)) rx_in ();
    rdbe_stream_if #(.W(rdbe_pkg::DATA_W)) rx_out ();

    // Receive words queue here so a busy memory stalls the protocol engine.
    assign rx_in.valid = rx_valid_i;
    assign rx_in.data = rx_data_i;
    assign rx_ready_o = rx_in.ready;

    rdbe_buf2 u_rxbuf (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .in_s(rx_in),
        .out_s(rx_out)
    );

    // A new command starts on the rising edge of terminal_active.
    assign start = (state_q == rdbe_pkg::ST_IDLE) && terminal_active_i && !ta_q;
    always_comb begin
        auto_ill = 1'b0;
        if (cmd_bcast_i && cmd_tx_i && !cmd_mode_i) begin
            auto_ill = 1'b1;
        end else if (cmd_bcast_i && cmd_mode_i && cmd_tx_i) begin
            if (cmd_sa_i == rdbe_pkg::MC_AUTO_A) begin
                auto_ill = 1'b1;
            end else if (cmd_sa_i == rdbe_pkg::MC_AUTO_B) begin
                auto_ill = !rev_1553a_i || status_word_transmit_option_i;
            end else begin
                auto_ill = cmd_sa_i[rdbe_pkg::SA_W-1] && !rev_1553a_i;
            end
        end else if (cmd_bcast_i && cmd_mode_i) begin
            if (cmd_sa_i == rdbe_pkg::MC_AUTO_A) begin
                auto_ill = rev_1553a_i;
            end else if (cmd_sa_i == rdbe_pkg::MC_AUTO_B) begin
                auto_ill = rev_1553a_i && status_word_transmit_option_i;
            end
        end
    end

    // Command fields and the table base are frozen for the whole message.
    // base held constant
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ta_q <= 1'b0;
            tr_q <= 1'b0;
            mode_q <= 1'b0;
            bc_q <= 1'b0;
            ill_q <= 1'b0;
            pp_q <= 1'b0;
            sa_q <= '0;
            wc_q <= '0;
            base_q <= '0;
        end else begin
            ta_q <= terminal_active_i;
            if (start) begin
                tr_q <= cmd_tx_i;
                mode_q <= cmd_mode_i;
                bc_q <= cmd_bcast_i;
                ill_q <= cmd_illegal_i || auto_ill;
                pp_q <= pingpong_en_i;
                sa_q <= cmd_sa_i;
                wc_q <= cmd_word_count_i;
                base_q <= table_base_i;
            end
        end
    end

    always_comb begin
        case ({tr_q, mode_q})
            2'b00: region = rdbe_pkg::OFS_RX_SA;
            2'b10: region = rdbe_pkg::OFS_TX_SA;
            2'b01: region = rdbe_pkg::OFS_RX_MC;
            default: region = rdbe_pkg::OFS_TX_MC;
        endcase
    end
    assign desc_addr = 16'(base_q) + region + 16'({sa_q, 2'b00});

    assign cw = desc_q[rdbe_pkg::IDX_CW];
    always_comb begin
        if (pp_q) begin
            sel_idx = cw[rdbe_pkg::CW_BUF_SEL] ? rdbe_pkg::IDX_PA : rdbe_pkg::IDX_PB;
        end else if (bc_q && !tr_q && cw[rdbe_pkg::CW_SEP_BC]) begin
            sel_idx = rdbe_pkg::IDX_PBC;
        end else begin
            sel_idx = rdbe_pkg::IDX_PA;
        end
    end
    assign ptr_base = desc_q[sel_idx] + rdbe_pkg::DATA_OFS;
    assign ptr_end = ptr_base + 16'(cnt_q);

    // Memory requests are launched only when no access is outstanding.
    // descriptor before data
    assign ld_rd_desc = (state_q == rdbe_pkg::ST_RDESC) && !mreq_q;
    assign rx_out.ready = (state_q == rdbe_pkg::ST_DATA) && !tr_q && (ill_q || !mreq_q);
    assign ld_wr_rx = rx_out.valid && rx_out.ready && !ill_q;
    assign ld_rd_tx = (state_q == rdbe_pkg::ST_DATA) && tr_q && !ill_q && !bc_q
                      && !mreq_q && !txv_q && !done_q && (cnt_q < wc_q);
    assign post_wr = (idx_q == rdbe_pkg::IDX_CW) || upd[idx_q];
    assign ld_wr_post = (state_q == rdbe_pkg::ST_POST) && !mreq_q && post_wr;
    assign post_step = (state_q == rdbe_pkg::ST_POST)
                       && ((mreq_q && mem_ack_i) || (!mreq_q && !post_wr));
    assign ld_wr_log = (state_q == rdbe_pkg::ST_LOG) && !mreq_q && log_need;
    assign launch = ld_rd_desc || ld_wr_rx || ld_rd_tx || ld_wr_post || ld_wr_log;

    // Received data runs out once the message is over and nothing is queued.
    assign data_end = done_q && !mreq_q && !rx_out.valid && !txv_q;

    assign cnt_f = cw[rdbe_pkg::CW_CNT_MSB:rdbe_pkg::CW_CNT_LSB];
    assign dec = !pp_q && !err_q && !ill_q && (cnt_f != rdbe_pkg::CNT_ZERO);
    assign bc_valid = bc_q && (tr_q || !ill_q);
    always_comb begin
        new_cw = cw;
        new_cw[rdbe_pkg::CW_CNT_MSB:rdbe_pkg::CW_CNT_LSB] = dec ? cnt_f - rdbe_pkg::CNT_ONE : cnt_f;
        new_cw[rdbe_pkg::CW_TOUCHED] = 1'b1;
        new_cw[rdbe_pkg::CW_BUF_SEL] = pp_q ? (sel_idx == rdbe_pkg::IDX_PA) : cw[rdbe_pkg::CW_BUF_SEL];
        new_cw[rdbe_pkg::CW_BC_SEEN] = cw[rdbe_pkg::CW_BC_SEEN] || bc_valid;
    end
    assign upd[rdbe_pkg::IDX_CW] = 1'b1;
    assign upd[rdbe_pkg::IDX_PA] = !pp_q && !err_q && !ill_q && (sel_idx == rdbe_pkg::IDX_PA);
    assign upd[rdbe_pkg::IDX_PB] = 1'b0;
    assign upd[rdbe_pkg::IDX_PBC] = !pp_q && !err_q && !ill_q && (sel_idx == rdbe_pkg::IDX_PBC);
    assign post_data = (idx_q == rdbe_pkg::IDX_CW) ? new_cw : ptr_end;

    assign ev[rdbe_pkg::EV_CZ] = cw[rdbe_pkg::CW_CZ_IRQ] && dec && (cnt_f == rdbe_pkg::CNT_ONE);
    assign ev[rdbe_pkg::EV_ACC] = cw[rdbe_pkg::CW_ACC_IRQ];
    assign ev[rdbe_pkg::EV_BRD] = cw[rdbe_pkg::CW_BRD_IRQ] && bc_q && !ill_q && !tr_q;
    assign log_need = |(ev & ~irq_mask_i);
    assign log_word = {ev, tr_q, mode_q, sa_q, 6'h00};

    // Address and data of the access about to be launched.
    always_comb begin
        ld_addr = desc_addr + 16'(idx_q);
        ld_data = post_data;
        case (state_q)
            rdbe_pkg::ST_DATA: begin
                ld_addr = ptr_end;
                ld_data = rx_out.data;
            end
            rdbe_pkg::ST_LOG: begin
                ld_addr = irq_log_addr_i;
                ld_data = log_word;
            end
            default: begin
                ld_addr = desc_addr + 16'(idx_q);
                ld_data = post_data;
            end
        endcase
    end

    // Request stays up with stable address and data until acknowledged.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mreq_q <= 1'b0;
            mwe_q <= 1'b0;
            maddr_q <= '0;
            mdata_q <= '0;
        end else if (launch) begin
            mreq_q <= 1'b1;
            mwe_q <= ld_wr_rx || ld_wr_post || ld_wr_log;
            maddr_q <= ld_addr;
            mdata_q <= ld_data;
        end else if (mem_ack_i) begin
            mreq_q <= 1'b0;
        end
    end
    assign mem_req_o = mreq_q;
    assign mem_we_o = mwe_q;
    assign mem_addr_o = maddr_q;
    assign mem_wdata_o = mdata_q;
    assign mem_burst_o = (state_q == rdbe_pkg::ST_POST);

    always_ff @(posedge clk_sys_i) begin
        if ((state_q == rdbe_pkg::ST_RDESC) && mreq_q && mem_ack_i) begin
            desc_q[idx_q] <= mem_rdata_i;
        end
    end

    // Main sequence: read descriptor, move data, post, then log.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= rdbe_pkg::ST_IDLE;
            idx_q <= 2'h0;
        end else begin
            case (state_q)
                rdbe_pkg::ST_IDLE: begin
                    idx_q <= 2'h0;
                    if (start) begin
                        state_q <= rdbe_pkg::ST_RDESC;
                    end
                end
                rdbe_pkg::ST_RDESC: begin
                    if (mreq_q && mem_ack_i) begin
                        idx_q <= idx_q + 2'h1;
                        if (idx_q == rdbe_pkg::IDX_PBC) begin
                            state_q <= rdbe_pkg::ST_DATA;
                        end
                    end
                end
                rdbe_pkg::ST_DATA: begin
                    if (data_end) begin
                        state_q <= rdbe_pkg::ST_POST;
                    end
                end
                rdbe_pkg::ST_POST: begin
                    if (post_step) begin
                        idx_q <= idx_q + 2'h1;
                        if (idx_q == rdbe_pkg::IDX_PBC) begin
                            state_q <= rdbe_pkg::ST_LOG;
                        end
                    end
                end
                rdbe_pkg::ST_LOG: begin
                    if (!log_need || (mreq_q && mem_ack_i)) begin
                        state_q <= rdbe_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= rdbe_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Message status: end and error are sticky until the next command.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            cnt_q <= '0;
        end else if (start) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            done_q <= done_q || msg_done_i;
            err_q <= err_q || msg_error_i;
            if (ld_wr_rx || ld_rd_tx) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    // Transmit words are held until the protocol engine takes them.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            txv_q <= 1'b0;
            txd_q <= '0;
        end else if ((state_q == rdbe_pkg::ST_DATA) && tr_q && mreq_q && mem_ack_i) begin
            txv_q <= 1'b1;
            txd_q <= mem_rdata_i;
        end else if (tx_ready_i) begin
            txv_q <= 1'b0;
        end
    end
    assign tx_valid_o = txv_q;
    assign tx_data_o = txd_q;

    // pending after processing
    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= '0;
        end else if ((state_q == rdbe_pkg::ST_LOG) && mreq_q && mem_ack_i) begin
            pend_q <= (pend_q & ~irq_clear_i) | (ev & ~irq_mask_i);
        end else begin
            pend_q <= pend_q & ~irq_clear_i;
        end
    end
    assign irq_pending_o = pend_q;
    assign message_irq_out_o = |pend_q;
    assign busy_o = (state_q != rdbe_pkg::ST_IDLE);

    // Helper: descriptor reads completed for the current command.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_cnt_q <= 3'h0;
        end else if (start) begin
            rd_cnt_q <= 3'h0;
        end else if ((state_q == rdbe_pkg::ST_RDESC) && mreq_q && mem_ack_i) begin
            rd_cnt_q <= rd_cnt_q + 3'h1;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_desc_addr: assert property (ld_rd_desc && idx_q == 2'h0 |=>
        mem_addr_o == desc_addr) else $error("descriptor address wrong");
    a_reads_first: assert property ($rose(state_q == rdbe_pkg::ST_DATA) |->
        rd_cnt_q == 3'h4) else $error("data phase before four reads");
    a_rx_offset: assert property (ld_wr_rx && cnt_q == 6'h00 |=>
        mem_we_o && mem_addr_o == desc_q[sel_idx] + 16'h0002) else $error("rx offset");
    a_tx_offset: assert property (ld_rd_tx && cnt_q == 6'h00 |=>
        !mem_we_o && mem_addr_o == desc_q[sel_idx] + 16'h0002) else $error("tx offset");
    a_bc_tx_quiet: assert property (bc_q && tr_q && busy_o |->
        !tx_valid_o) else $error("broadcast transmit sent data");
    a_log_order: assert property ($rose(state_q == rdbe_pkg::ST_LOG) |->
        $past(state_q == rdbe_pkg::ST_POST) && $past(mem_burst_o)) else $error("log early");
    a_pp_keep: assert property (ld_wr_post && pp_q |->
        idx_q == rdbe_pkg::IDX_CW) else $error("pointer written in alternating mode");
    a_ill_count: assert property (ld_wr_post && idx_q == 2'h0 && ill_q |=>
        mem_wdata_o[15:8] == $past(cw[15:8])) else $error("count changed on illegal");
    a_touched: assert property (ld_wr_post && idx_q == 2'h0 |=>
        mem_we_o && mem_wdata_o[4]) else $error("touched flag not set");
    a_irq_after: assert property ($rose(message_irq_out_o) |->
        $past(state_q == rdbe_pkg::ST_LOG, 1)) else $error("interrupt outside log");

    c_rx_msg: cover property (state_q == rdbe_pkg::ST_POST && !tr_q && cnt_q > 6'h01);
    c_tx_msg: cover property (tx_valid_o && tx_ready_i ##[1:40] state_q == rdbe_pkg::ST_POST);
    c_bc_rx: cover property (ld_wr_rx && sel_idx == rdbe_pkg::IDX_PBC);
    c_irq: cover property ($rose(message_irq_out_o));
endmodule : rdbe_engine

// ---- test/rdbe_engine_tb.sv ----
// Bench for the descriptor engine: six commands against the memory model.
// Assumes a 250 MHz clock and a table placed above the low 32 words.
`timescale 1ns/1ps
module rdbe_engine_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pp, il, ta, tx, md, bc, err, done, rxv, req, we, ack, rxr, txv, mirq, busy;
    logic rev, swo;
    logic [4:0] sa;
    logic [5:0] wc;
    logic [2:0] clr, pend;
    logic [11:0] base;
    logic [15:0] rxd, txd, adr, wd, rd, txw;
    int failures = 0;
    int num_checks = 0;
    rdbe_mem m (.clk_sys_i(clk), .req_i(req), .we_i(we), .addr_i(adr), .wdata_i(wd),
        .rdata_o(rd), .ack_o(ack));
    rdbe_engine DUT (.clk_sys_i(clk), .rst_n_i(rst_n), .table_base_i(base),
        .pingpong_en_i(pp), .rev_1553a_i(rev), .status_word_transmit_option_i(swo),
        .terminal_active_i(ta), .cmd_tx_i(tx), .cmd_mode_i(md), .cmd_sa_i(sa),
        .cmd_bcast_i(bc), .cmd_illegal_i(il), .cmd_word_count_i(wc), .msg_error_i(err),
        .msg_done_i(done), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_ready_o(rxr),
        .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(1'b1), .mem_req_o(req),
        .mem_we_o(we), .mem_burst_o(), .mem_addr_o(adr), .mem_wdata_o(wd),
        .mem_rdata_i(rd), .mem_ack_i(ack), .irq_mask_i(3'h0), .irq_log_addr_i(16'h0040),
        .irq_clear_i(clr), .irq_pending_o(pend), .message_irq_out_o(mirq), .busy_o(busy));
    initial forever #2 clk = ~clk;
    task automatic end_sim();
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [15:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // four descriptor words loaded into the table before the command starts.
    task automatic desc(input logic [15:0] a, c, p, q, r);
        m.mem[a] = c;
        m.mem[a + 16'h1] = p;
        m.mem[a + 16'h2] = q;
        m.mem[a + 16'h3] = r;
    endtask : desc
    // Words are offered after each edge and counted only when the buffer had room.
    task automatic run_cmd(input logic t, mc, b, e, input logic [4:0] s, input int n);
        int i;
        i = 0;
        clr <= 3'h7;
        @(posedge clk);
        {clr, tx, md, bc, sa, wc, ta, rxv} <= {3'h0, t, mc, b, s, 6'(n), 1'b1, !t};
        rxd <= 16'hC000;
        repeat (60) begin
            @(negedge clk);
            i += int'(rxv && rxr);
            if (txv) txw = txd;
            @(posedge clk);
            err <= e;
            rxv <= !t && i < n;
            rxd <= 16'hC000 + 16'(i);
        end
        done <= 1'b1;
        @(posedge clk);
        {done, ta, err} <= 3'h0;
        i = 0;
        while (i < 300) begin
            @(negedge clk);
            i = busy ? i + 1 : 300;
        end
        // A command that never goes idle ends the run as a failure.
        if (busy) begin
            failures++;
            end_sim();
        end
        @(posedge clk);
    endtask : run_cmd
    // receive at base plus 12, count one to zero.
    task automatic s_rx();
        desc(16'h010C, 16'h01C0, 16'h2000, 16'h0, 16'h0);
        run_cmd(1'b0, 1'b0, 1'b0, 1'b0, 5'h03, 2);
        chk("rx w0", 16'hC000, m.mem[16'h2002]);
        chk("rx w1", 16'hC001, m.mem[16'h2003]);
        chk("rx cw", 16'h00D0, m.mem[16'h010C]);
        chk("rx pa", 16'h2004, m.mem[16'h010D]);
        chk("rx pend", 16'h6, 16'(pend));
        chk("msg irq", 16'h1, 16'(mirq));
        chk("log", 16'hC0C0, m.mem[16'h0040]);
    endtask : s_rx
    // transmit mode code with an error.
    task automatic s_tx();
        desc(16'h0294, 16'h0, 16'h3000, 16'h0, 16'h0);
        m.mem[16'h3002] = 16'hA5A5;
        run_cmd(1'b1, 1'b1, 1'b0, 1'b1, 5'h05, 1);
        chk("tx word", 16'hA5A5, txw);
        chk("tx cw", 16'h0010, m.mem[16'h0294]);
        chk("tx pa", 16'h3000, m.mem[16'h0295]);
    endtask : s_tx
    // broadcast receive into its own buffer.
    task automatic s_bc();
        desc(16'h011C, 16'h0021, 16'h2100, 16'h0, 16'h4000);
        run_cmd(1'b0, 1'b0, 1'b1, 1'b0, 5'h07, 1);
        chk("bc w0", 16'hC000, m.mem[16'h4002]);
        chk("bc cw", 16'h0033, m.mem[16'h011C]);
        chk("bc pbc", 16'h4003, m.mem[16'h011F]);
        chk("bc pa", 16'h2100, m.mem[16'h011D]);
        chk("bc pend", 16'h1, 16'(pend));
    endtask : s_bc
    // alternating mode picks the second pointer.
    task automatic s_pp();
        pp <= 1'b1;
        desc(16'h0124, 16'h0, 16'h2200, 16'h5000, 16'h0);
        run_cmd(1'b0, 1'b0, 1'b0, 1'b0, 5'h09, 1);
        pp <= 1'b0;
        chk("pp w0", 16'hC000, m.mem[16'h5002]);
        chk("pp pb", 16'h5000, m.mem[16'h0126]);
        chk("pp cw", 16'h0010, m.mem[16'h0124]);
    endtask : s_pp
    // broadcast transmit refused, then an automatically illegal mode code.
    task automatic s_ill();
        txw = 16'h0000;
        desc(16'h0184, 16'h0040, 16'h3100, 16'h0, 16'h0);
        run_cmd(1'b1, 1'b0, 1'b1, 1'b0, 5'h01, 1);
        chk("btx word", 16'h0000, txw);
        chk("btx cw", 16'h0052, m.mem[16'h0184]);
        chk("btx pa", 16'h3100, m.mem[16'h0185]);
        chk("btx pend", 16'h2, 16'(pend));
        {rev, swo} <= 2'h3;
        desc(16'h0208, 16'h0100, 16'h2300, 16'h0, 16'h0);
        m.mem[16'h2302] = 16'h1234;
        run_cmd(1'b0, 1'b1, 1'b1, 1'b0, 5'h02, 1);
        {rev, swo} <= 2'h0;
        chk("bmc w0", 16'h1234, m.mem[16'h2302]);
        chk("bmc cw", 16'h0110, m.mem[16'h0208]);
        chk("bmc pa", 16'h2300, m.mem[16'h0209]);
    endtask : s_ill
    // A hang stops the run well past the expected few hundred cycles.
    initial begin
        #40000;
        failures++;
        end_sim();
    end
    initial begin
        {pp, il, ta, tx, md, bc, err, done, rxv, rev, swo, sa, wc, clr, rxd} = '0;
        base = 12'h100;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        s_rx();
        s_tx();
        s_bc();
        s_pp();
        s_ill();
        end_sim();
    end
endmodule : rdbe_engine_tb

// ---- test/rdbe_mem.sv ----
// Memory model that answers the engine's word accesses.
// Assumes one clock; the bench loads and inspects mem directly.
`timescale 1ns/1ps
module rdbe_mem (
    input wire logic clk_sys_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    output logic ack_o
);
    logic [15:0] mem [0:65535];
    initial begin
        ack_o = 1'b0;
        rdata_o = 16'h0000;
    end
    // four-word descriptors: one access per request, one wait state.
    // Read data toggles when idle, so a stale word is never mistaken for an answer.
    always @(posedge clk_sys_i) begin
        ack_o <= req_i && !ack_o;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            rdata_o <= mem[addr_i];
            if (we_i) begin
                mem[addr_i] <= wdata_i;
            end
        end
    end
endmodule : rdbe_mem
